// ==== design/dds_mode_clock_config.sv ====
// synthesizer clock, programming-port and mode configuration with the single-tone core
// Summary of operation
// - cosine path uses inverse sinc after reset; bypass bit in register 20 skips it
// - clock multiplier factor is an integer from four to twenty
// - five-bit field in register 1E holds the factor as plain binary
// - system clock is multiplier output when engaged, else reference input
// - bypass bit in register 1E disables the multiplier
// - differential select high uses complementary pair, low uses true input only
// - port select high picks parallel port, low picks serial port
// - serial words go least significant bit first when bit-order control is high
// - readback pin control high reads on dedicated pin, low on shared data pin
// - three-bit mode field in register 1F selects the operating mode
// - master reset or a written single-tone code gives single-tone mode
// - single-tone accumulates first tuning word, which resets to zero
// - after reset output is 0 Hz, 0 phase, zero amplitude
// - tuning word changes keep accumulator phase, no phase reset
// - 48-bit accumulator, output frequency is word times clock over two^48
// - second phase adjust only in BPSK; sweep only in ramped FSK and chirp
// - settings update while running over parallel or serial port
// - single-tone gives 12-bit amplitude and 14-bit phase offset control
`timescale 1ns/100ps
module dds_mode_clock_config #(
	parameter int ACC_W   = 48,
	parameter int PHASE_W = 14,
	parameter int AMP_W   = 12
) (
	// clock and master reset
	input  wire logic                  CLK,
	input  wire logic                  RST,
	// reference clock pins and multiplier output
	input  wire logic                  REF_CLK_IN,
	input  wire logic                  REF_CLK_COMP,
	input  wire logic                  DIFF_CLK_SEL,
	input  wire logic                  PLL_CLK,
	output logic                       SYS_CLK_OUT,
	output dds_cfg_pkg::clk_cfg_t      CLK_CFG,
	// port select and parallel port
	input  wire logic                  PORT_SEL,
	input  wire logic [5:0]            PADDR,
	input  wire logic [7:0]            PDATA_IN,
	output logic      [7:0]            PDATA_OUT,
	output logic                       PDATA_OE,
	input  wire logic                  WR_N,
	input  wire logic                  RD_N,
	// serial port
	input  wire logic                  SCLK,
	input  wire logic                  CS_N,
	input  wire logic                  SDIO_IN,
	output logic                       SDIO_OUT,
	output logic                       SDIO_OE,
	output logic                       READBACK_OUT,
	// mode and single-pin control
	input  wire logic                  SINGLE_PIN_SEL,
	output dds_cfg_pkg::mode_t         MODE,
	output dds_cfg_pkg::mode_caps_t    MODE_CAPS,
	// signal path
	output logic                       INV_SINC_EN,
	output logic      [PHASE_W-1:0]    PHASE_OUT,
	output logic      [AMP_W-1:0]      AMP_OUT
);
	logic [7:0]  regs_q [dds_cfg_pkg::NUM_REGS];
	logic        wr_n_q;
	logic        sclk_q;
	logic        wr_en;
	logic [5:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  pdata_q;
	logic [7:0]  ser_sh_q;
	logic [7:0]  ser_out_q;
	logic [3:0]  bit_cnt_q;
	logic        ser_rd_q;
	logic [5:0]  ser_addr_q;
	logic        ser_bit_q;
	logic        sclk_rise;
	logic [7:0]  ser_next;
	logic [7:0]  ser_rd_byte;
	logic [ACC_W-1:0] tune1;
	logic [ACC_W-1:0] tune2;
	logic [ACC_W-1:0] tune_sel;
	logic [ACC_W-1:0] acc_q;
	logic [PHASE_W-1:0] padj1;
	logic [PHASE_W-1:0] padj2;
	logic [PHASE_W-1:0] phase_q;
	logic [AMP_W-1:0]   amp_q;
	logic [4:0]  mult_raw;
	logic [2:0]  mode_code;
	logic        lsb_first;
	logic        rb_pin;
	logic        ref_sel;
	dds_cfg_pkg::mode_t      mode_q;
	dds_cfg_pkg::ser_state_t ser_q;
	dds_cfg_pkg::clk_cfg_t   clk_cfg_q;

	function automatic logic reg_mapped(input logic [5:0] a);
		reg_mapped = (a <= dds_cfg_pkg::TUNE2_BASE + 6'(dds_cfg_pkg::TUNE_BYTES - 1)) ||
			(a >= dds_cfg_pkg::CLKMUL_ADDR && a <= dds_cfg_pkg::AMP_HI);
	endfunction

	function automatic logic [7:0] rd_byte(input logic [5:0] a);
		rd_byte = reg_mapped(a) ? regs_q[a] : 8'h00;
	endfunction

	// control fields decoded from the register file
	assign mult_raw  = regs_q[dds_cfg_pkg::CLKMUL_ADDR][dds_cfg_pkg::MULT_LSB +: dds_cfg_pkg::MULT_W];
	assign mode_code = regs_q[dds_cfg_pkg::MODE_ADDR][dds_cfg_pkg::MODE_LSB +: dds_cfg_pkg::MODE_W];
	assign lsb_first = regs_q[dds_cfg_pkg::OUTSER_ADDR][dds_cfg_pkg::LSB_FIRST_BIT];
	assign rb_pin    = regs_q[dds_cfg_pkg::OUTSER_ADDR][dds_cfg_pkg::RB_PIN_BIT];

	genvar g;
	generate
		for (g = 0; g < dds_cfg_pkg::TUNE_BYTES; g++) begin : g_tune
			assign tune1[8*g +: 8] = regs_q[dds_cfg_pkg::TUNE1_BASE + 6'(g)];
			assign tune2[8*g +: 8] = regs_q[dds_cfg_pkg::TUNE2_BASE + 6'(g)];
		end
	endgenerate

	assign padj1 = PHASE_W'({regs_q[dds_cfg_pkg::PHASE1_HI], regs_q[dds_cfg_pkg::PHASE1_LO]});
	assign padj2 = PHASE_W'({regs_q[dds_cfg_pkg::PHASE2_HI], regs_q[dds_cfg_pkg::PHASE2_LO]});

	// write source follows the port select pin
	assign sclk_rise = SCLK & ~sclk_q;
	assign ser_rd_byte = rd_byte(ser_next[5:0]);
	always_comb begin
		if (PORT_SEL) begin
			wr_en   = wr_n_q & ~WR_N;
			wr_addr = PADDR;
			wr_data = PDATA_IN;
		end else begin
			wr_en   = (ser_q == dds_cfg_pkg::SER_DATA) && sclk_rise && !CS_N && !ser_rd_q &&
				(bit_cnt_q == dds_cfg_pkg::SER_BITS - 4'h1);
			wr_addr = ser_addr_q;
			wr_data = ser_next;
		end
	end

	// register file, updated at any time while the core runs
	always_ff @(posedge CLK) begin
		if (RST) begin
			for (int i = 0; i < dds_cfg_pkg::NUM_REGS; i++) begin
				regs_q[i] <= dds_cfg_pkg::REG_RESET;
			end
		end else if (wr_en && reg_mapped(wr_addr)) begin
			regs_q[wr_addr] <= wr_data;
		end
	end

	// parallel port: write on falling strobe, read data registered
	always_ff @(posedge CLK) begin
		if (RST) begin
			wr_n_q  <= 1'b1;
			pdata_q <= 8'h00;
		end else begin
			wr_n_q  <= WR_N;
			pdata_q <= rd_byte(PADDR);
		end
	end
	assign PDATA_OUT = pdata_q;
	assign PDATA_OE  = PORT_SEL & ~RD_N;

	// serial shift with selectable bit order
	always_comb begin
		if (lsb_first) begin
			ser_next = {SDIO_IN, ser_sh_q[7:1]};
		end else begin
			ser_next = {ser_sh_q[6:0], SDIO_IN};
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			sclk_q     <= 1'b0;
			ser_q      <= dds_cfg_pkg::SER_IDLE;
			ser_sh_q   <= 8'h00;
			ser_out_q  <= 8'h00;
			bit_cnt_q  <= 4'h0;
			ser_rd_q   <= 1'b0;
			ser_addr_q <= 6'h00;
			ser_bit_q  <= 1'b0;
		end else begin
			sclk_q <= SCLK;
			if (CS_N || PORT_SEL) begin
				ser_q     <= dds_cfg_pkg::SER_IDLE;
				bit_cnt_q <= 4'h0;
				ser_rd_q  <= 1'b0;
			end else begin
				case (ser_q)
					dds_cfg_pkg::SER_IDLE: begin
						ser_q <= dds_cfg_pkg::SER_INSTR;
					end
					dds_cfg_pkg::SER_INSTR: begin
						if (sclk_rise) begin
							ser_sh_q  <= ser_next;
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (bit_cnt_q == dds_cfg_pkg::SER_BITS - 4'h1) begin
								ser_q      <= dds_cfg_pkg::SER_DATA;
								bit_cnt_q  <= 4'h0;
								ser_rd_q   <= ser_next[dds_cfg_pkg::SER_READ_BIT];
								ser_addr_q <= ser_next[5:0];
								ser_out_q  <= ser_rd_byte;
								ser_bit_q  <= lsb_first ? ser_rd_byte[0] : ser_rd_byte[7];
							end
						end
					end
					dds_cfg_pkg::SER_DATA: begin
						if (sclk_rise) begin
							ser_sh_q  <= ser_next;
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (lsb_first) begin
								ser_out_q <= {1'b0, ser_out_q[7:1]};
								ser_bit_q <= ser_out_q[1];
							end else begin
								ser_out_q <= {ser_out_q[6:0], 1'b0};
								ser_bit_q <= ser_out_q[6];
							end
							if (bit_cnt_q == dds_cfg_pkg::SER_BITS - 4'h1) begin
								ser_q     <= dds_cfg_pkg::SER_INSTR;
								bit_cnt_q <= 4'h0;
								ser_rd_q  <= 1'b0;
							end
						end
					end
					default: begin
						ser_q <= dds_cfg_pkg::SER_IDLE;
					end
				endcase
			end
		end
	end

	// readback goes to the shared pin or the dedicated pin
	assign SDIO_OE  = (ser_q == dds_cfg_pkg::SER_DATA) && ser_rd_q && !rb_pin;
	assign SDIO_OUT = ser_bit_q;
	assign READBACK_OUT = rb_pin ? ser_bit_q : 1'b0;

	// clock source and multiplier settings
	always_ff @(posedge CLK) begin
		if (RST) begin
			clk_cfg_q <= '{pll_bypass: 1'b0, pll_range: 1'b0, factor: dds_cfg_pkg::MULT_MIN};
		end else begin
			clk_cfg_q.pll_bypass <= regs_q[dds_cfg_pkg::CLKMUL_ADDR][dds_cfg_pkg::PLL_BYP_BIT];
			clk_cfg_q.pll_range  <= regs_q[dds_cfg_pkg::CLKMUL_ADDR][dds_cfg_pkg::RANGE_BIT];
			if (mult_raw < dds_cfg_pkg::MULT_MIN) begin
				clk_cfg_q.factor <= dds_cfg_pkg::MULT_MIN;
			end else if (mult_raw > dds_cfg_pkg::MULT_MAX) begin
				clk_cfg_q.factor <= dds_cfg_pkg::MULT_MAX;
			end else begin
				clk_cfg_q.factor <= mult_raw;
			end
		end
	end
	assign CLK_CFG = clk_cfg_q;
	assign ref_sel = DIFF_CLK_SEL ? (REF_CLK_IN & ~REF_CLK_COMP) : REF_CLK_IN;
	assign SYS_CLK_OUT = clk_cfg_q.pll_bypass ? ref_sel : PLL_CLK;

	// operating mode decode
	always_ff @(posedge CLK) begin
		if (RST) begin
			mode_q <= dds_cfg_pkg::MODE_SINGLE;
		end else begin
			case (mode_code)
				dds_cfg_pkg::CODE_SINGLE: mode_q <= dds_cfg_pkg::MODE_SINGLE;
				dds_cfg_pkg::CODE_FSK:    mode_q <= dds_cfg_pkg::MODE_FSK;
				dds_cfg_pkg::CODE_RFSK:   mode_q <= dds_cfg_pkg::MODE_RFSK;
				dds_cfg_pkg::CODE_CHIRP:  mode_q <= dds_cfg_pkg::MODE_CHIRP;
				dds_cfg_pkg::CODE_BPSK:   mode_q <= dds_cfg_pkg::MODE_BPSK;
				default:                  mode_q <= dds_cfg_pkg::MODE_SINGLE;
			endcase
		end
	end
	assign MODE = mode_q;

	// functions permitted by each mode
	always_comb begin
		MODE_CAPS.tune2_en = (mode_q == dds_cfg_pkg::MODE_FSK) ||
			(mode_q == dds_cfg_pkg::MODE_RFSK);
		MODE_CAPS.pin_en       = mode_q != dds_cfg_pkg::MODE_SINGLE;
		MODE_CAPS.phase2_en    = mode_q == dds_cfg_pkg::MODE_BPSK;
		MODE_CAPS.phase_mod_en = mode_q != dds_cfg_pkg::MODE_BPSK;
		MODE_CAPS.sweep_en     = (mode_q == dds_cfg_pkg::MODE_RFSK) ||
			(mode_q == dds_cfg_pkg::MODE_CHIRP);
	end
	assign INV_SINC_EN = ~regs_q[dds_cfg_pkg::OUTSER_ADDR][dds_cfg_pkg::INVSINC_BYP_BIT];

	// phase accumulator, never cleared by a tuning change
	assign tune_sel = (MODE_CAPS.tune2_en && SINGLE_PIN_SEL) ? tune2 : tune1;
	always_ff @(posedge CLK) begin
		if (RST) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_q + tune_sel;
		end
	end

	// phase offset and amplitude
	always_ff @(posedge CLK) begin
		if (RST) begin
			phase_q <= '0;
			amp_q   <= '0;
		end else begin
			if (MODE_CAPS.phase2_en && SINGLE_PIN_SEL) begin
				phase_q <= acc_q[ACC_W-1 -: PHASE_W] + padj2;
			end else begin
				phase_q <= acc_q[ACC_W-1 -: PHASE_W] + padj1;
			end
			amp_q <= AMP_W'({regs_q[dds_cfg_pkg::AMP_HI], regs_q[dds_cfg_pkg::AMP_LO]});
		end
	end
	assign PHASE_OUT = phase_q;
	assign AMP_OUT   = amp_q;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	inv_sinc_bypass_a: assert property (wr_en && reg_mapped(wr_addr) &&
		wr_addr == dds_cfg_pkg::OUTSER_ADDR && wr_data[dds_cfg_pkg::INVSINC_BYP_BIT]
		|=> !INV_SINC_EN)
		else $error("inverse sinc not bypassed");
	mult_factor_range_a: assert property (CLK_CFG.factor >= dds_cfg_pkg::MULT_MIN &&
		CLK_CFG.factor <= dds_cfg_pkg::MULT_MAX)
		else $error("multiplier factor out of range");
	mult_code_load_a: assert property (wr_en && wr_addr == dds_cfg_pkg::CLKMUL_ADDR &&
		wr_data[4:0] >= dds_cfg_pkg::MULT_MIN && wr_data[4:0] <= dds_cfg_pkg::MULT_MAX
		|=> ##1 CLK_CFG.factor == $past(wr_data[4:0], 2))
		else $error("multiplier factor not loaded");
	pll_bypass_set_a: assert property (wr_en && wr_addr == dds_cfg_pkg::CLKMUL_ADDR &&
		wr_data[dds_cfg_pkg::PLL_BYP_BIT] |=> ##1 CLK_CFG.pll_bypass)
		else $error("multiplier not bypassed");
	mode_reset_a: assert property (disable iff (1'b0)
		RST |=> mode_q == dds_cfg_pkg::MODE_SINGLE)
		else $error("mode not single-tone after reset");
	undef_mode_a: assert property (wr_en && wr_addr == dds_cfg_pkg::MODE_ADDR &&
		wr_data[2:0] > dds_cfg_pkg::CODE_BPSK |=> ##1 mode_q == dds_cfg_pkg::MODE_SINGLE)
		else $error("undefined code not single-tone");
	single_tone_acc_a: assert property (mode_q == dds_cfg_pkg::MODE_SINGLE
		|=> acc_q == $past(acc_q) + $past(tune1))
		else $error("accumulator not stepping by first word");
	port_sel_read_a: assert property (!PORT_SEL |-> !PDATA_OE)
		else $error("parallel bus driven in serial mode");
	readback_pin_a: assert property (rb_pin |-> !SDIO_OE)
		else $error("shared pin driven with dedicated readback");
	phase2_caps_a: assert property (mode_q != dds_cfg_pkg::MODE_BPSK |->
		!MODE_CAPS.phase2_en && MODE_CAPS.phase_mod_en)
		else $error("second phase adjust outside BPSK");

	cover_ser_read_c: cover property (SDIO_OE ##1 !SDIO_OE);
	cover_par_write_c: cover property (PORT_SEL && wr_en);
	cover_fsk_tune2_c: cover property (MODE_CAPS.tune2_en && SINGLE_PIN_SEL);
	cover_bypass_c: cover property (CLK_CFG.pll_bypass && DIFF_CLK_SEL);
endmodule

// ==== inc/dds_cfg_pkg.sv ====
// constants, register map and carrier types for the synthesizer configuration block
package dds_cfg_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int TUNE_BYTES = 6;
	localparam int NUM_REGS = 64;

	localparam logic [5:0] PHASE1_LO   = 6'h00;
	localparam logic [5:0] PHASE1_HI   = 6'h01;
	localparam logic [5:0] PHASE2_LO   = 6'h02;
	localparam logic [5:0] PHASE2_HI   = 6'h03;
	localparam logic [5:0] TUNE1_BASE  = 6'h04;
	localparam logic [5:0] TUNE2_BASE  = 6'h0A;
	localparam logic [5:0] CLKMUL_ADDR = 6'h1E;
	localparam logic [5:0] MODE_ADDR   = 6'h1F;
	localparam logic [5:0] OUTSER_ADDR = 6'h20;
	localparam logic [5:0] AMP_LO      = 6'h21;
	localparam logic [5:0] AMP_HI      = 6'h22;

	localparam logic [7:0] REG_RESET = 8'h00;

	// clock multiplier control fields
	localparam int MULT_LSB    = 0;
	localparam int MULT_W      = 5;
	localparam int PLL_BYP_BIT = 5;
	localparam int RANGE_BIT   = 6;
	localparam logic [4:0] MULT_MIN = 5'h04;
	localparam logic [4:0] MULT_MAX = 5'h14;

	// operating mode field
	localparam int MODE_LSB = 0;
	localparam int MODE_W   = 3;
	localparam logic [2:0] CODE_SINGLE = 3'h0;
	localparam logic [2:0] CODE_FSK    = 3'h1;
	localparam logic [2:0] CODE_RFSK   = 3'h2;
	localparam logic [2:0] CODE_CHIRP  = 3'h3;
	localparam logic [2:0] CODE_BPSK   = 3'h4;

	// output and serial control fields
	localparam int LSB_FIRST_BIT   = 0;
	localparam int RB_PIN_BIT      = 1;
	localparam int INVSINC_BYP_BIT = 6;

	// serial framing
	localparam logic [3:0] SER_BITS = 4'h8;
	localparam int SER_READ_BIT = 7;

	typedef enum logic [4:0] {
		MODE_SINGLE = 5'b00001,
		MODE_FSK    = 5'b00010,
		MODE_RFSK   = 5'b00100,
		MODE_CHIRP  = 5'b01000,
		MODE_BPSK   = 5'b10000
	} mode_t;

	typedef enum logic [2:0] {
		SER_IDLE  = 3'b001,
		SER_INSTR = 3'b010,
		SER_DATA  = 3'b100
	} ser_state_t;

	typedef struct packed {
		logic       pll_bypass;
		logic       pll_range;
		logic [4:0] factor;
	} clk_cfg_t;

	typedef struct packed {
		logic tune2_en;
		logic pin_en;
		logic phase2_en;
		logic phase_mod_en;
		logic sweep_en;
	} mode_caps_t;
endpackage

// ==== testbench/dds_host_model.sv ====
// host model that programs the block over its parallel and serial ports
`timescale 1ns/100ps
module dds_host_model (
	// clock
	input  wire logic       clk,
	// parallel port
	output logic            port_sel,
	output logic      [5:0] paddr,
	output logic      [7:0] pdata,
	output logic            wr_n,
	output logic            rd_n,
	input  wire logic [7:0] pdata_out,
	// serial port
	output logic            sclk,
	output logic            cs_n,
	output logic            sdio,
	input  wire logic       sdio_w,
	input  wire logic       rb_in
);
	// serial settings of the device as last written by this host over the serial port
	logic lsb_first;
	logic rb_sel;

	initial begin
		port_sel = 1'b1;
		paddr = 6'h00;
		pdata = 8'h00;
		wr_n = 1'b1;
		rd_n = 1'b1;
		sclk = 1'b0;
		cs_n = 1'b1;
		sdio = 1'b0;
		lsb_first = 1'b0;
		rb_sel = 1'b0;
	end

	// one byte write, strobe back high for an edge before the next
	task automatic pw(input logic [5:0] a, input logic [7:0] d);
		port_sel <= 1'b1;
		paddr <= a;
		pdata <= d;
		wr_n <= 1'b0;
		@(posedge clk);
		wr_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic pr(input logic [5:0] a, output logic [7:0] d);
		port_sel <= 1'b1;
		paddr <= a;
		rd_n <= 1'b0;
		repeat (3) @(posedge clk);
		d = pdata_out;
		rd_n <= 1'b1;
		@(posedge clk);
	endtask

	// one serial bit: read bit sampled at the end of the low phase
	task automatic sb(input logic b, output logic r);
		sclk <= 1'b0;
		sdio <= b;
		repeat (2) @(posedge clk);
		r = rb_sel ? rb_in : sdio_w;
		sclk <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	// instruction byte then data byte, order per bit-order setting
	task automatic sx(input logic rd, input logic [5:0] a, input logic [7:0] d,
			output logic [7:0] q);
		logic [7:0] ins;
		logic b;
		ins = {rd, 1'b0, a};
		port_sel <= 1'b0;
		cs_n <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			sb(ins[lsb_first ? i : 7 - i], b);
		end
		for (int i = 0; i < 8; i++) begin
			sb(d[lsb_first ? i : 7 - i], q[lsb_first ? i : 7 - i]);
		end
		sclk <= 1'b0;
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		port_sel <= 1'b1;
		repeat (2) @(posedge clk);
		if (!rd && a == dds_cfg_pkg::OUTSER_ADDR) begin
			lsb_first = d[dds_cfg_pkg::LSB_FIRST_BIT];
			rb_sel = d[dds_cfg_pkg::RB_PIN_BIT];
		end
	endtask
endmodule

// ==== testbench/tb_dds_mode_clock_config.sv ====
// self-checking bench for the synthesizer configuration block
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module tb_dds_mode_clock_config;
	logic                        clk, rst, ref_in, ref_comp, diff_sel, pll_clk, pin_sel;
	logic                        port_sel, wr_n, rd_n, sclk, cs_n, h_sdio, sdio_w;
	logic                        sys_clk, pdata_oe, sdio_out, sdio_oe, rb_out, inv_sinc;
	logic [5:0]                  paddr;
	logic [7:0]                  pdata, pdata_out, q;
	logic [13:0]                 phase, p0, p1;
	logic [11:0]                 amp;
	dds_cfg_pkg::clk_cfg_t       clk_cfg;
	dds_cfg_pkg::mode_t          mode;
	dds_cfg_pkg::mode_caps_t     caps;
	int                          mismatches = 0;
	int                          samples_checked = 0;
	logic [4:0]                  fin [6] = '{5'h03, 5'h04, 5'h0A, 5'h14, 5'h15, 5'h1F};
	logic [4:0]                  fex [6] = '{5'h04, 5'h04, 5'h0A, 5'h14, 5'h14, 5'h14};
	logic [2:0]                  mseq [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5, 3'h6, 3'h7};
	logic [4:0]                  cex [8] = '{5'h02, 5'h1A, 5'h1B, 5'h0B, 5'h0C, 5'h02, 5'h02, 5'h02};
	dds_cfg_pkg::mode_t          mex [8] = '{dds_cfg_pkg::MODE_SINGLE, dds_cfg_pkg::MODE_FSK,
		dds_cfg_pkg::MODE_RFSK, dds_cfg_pkg::MODE_CHIRP, dds_cfg_pkg::MODE_BPSK,
		dds_cfg_pkg::MODE_SINGLE, dds_cfg_pkg::MODE_SINGLE, dds_cfg_pkg::MODE_SINGLE};

	// shared serial data wire: the device wins while it drives
	assign sdio_w = sdio_oe ? sdio_out : h_sdio;

	dds_mode_clock_config dut (
		.CLK(clk), .RST(rst), .REF_CLK_IN(ref_in), .REF_CLK_COMP(ref_comp),
		.DIFF_CLK_SEL(diff_sel), .PLL_CLK(pll_clk), .SYS_CLK_OUT(sys_clk), .CLK_CFG(clk_cfg),
		.PORT_SEL(port_sel), .PADDR(paddr), .PDATA_IN(pdata), .PDATA_OUT(pdata_out),
		.PDATA_OE(pdata_oe), .WR_N(wr_n), .RD_N(rd_n), .SCLK(sclk), .CS_N(cs_n),
		.SDIO_IN(sdio_w), .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .READBACK_OUT(rb_out),
		.SINGLE_PIN_SEL(pin_sel), .MODE(mode), .MODE_CAPS(caps), .INV_SINC_EN(inv_sinc),
		.PHASE_OUT(phase), .AMP_OUT(amp)
	);

	dds_host_model host (
		.clk(clk), .port_sel(port_sel), .paddr(paddr), .pdata(pdata), .wr_n(wr_n),
		.rd_n(rd_n), .pdata_out(pdata_out), .sclk(sclk), .cs_n(cs_n), .sdio(h_sdio),
		.sdio_w(sdio_w), .rb_in(rb_out)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic end_sim;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		mismatches++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		ref_in = 1'b0;
		ref_comp = 1'b0;
		diff_sel = 1'b0;
		pll_clk = 1'b0;
		pin_sel = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(mode, dds_cfg_pkg::MODE_SINGLE)
		`CHK(inv_sinc, 1'b1)
		`CHK(clk_cfg, 7'h04)
		`CHK({phase, amp}, 26'h0)
		for (int a = 0; a <= 'h22; a++) begin
			host.pr(6'(a), q);
			`CHK(q, 8'h00)
		end
		host.pw(dds_cfg_pkg::OUTSER_ADDR, 8'h40);
		`CHK(inv_sinc, 1'b0)
		host.pw(dds_cfg_pkg::OUTSER_ADDR, 8'h00);
		`CHK(inv_sinc, 1'b1)
		for (int i = 0; i < 6; i++) begin
			host.pw(dds_cfg_pkg::CLKMUL_ADDR, {3'h0, fin[i]});
			repeat (2) @(posedge clk);
			`CHK(clk_cfg, {2'b00, fex[i]})
		end
		// range bit set as for a fast system clock
		host.pw(dds_cfg_pkg::CLKMUL_ADDR, 8'h6A);
		repeat (2) @(posedge clk);
		`CHK(clk_cfg, 7'h6A)
		for (int b = 0; b < 2; b++) begin
			host.pw(dds_cfg_pkg::CLKMUL_ADDR, b ? 8'h2A : 8'h0A);
			for (int i = 0; i < 16; i++) begin
				{diff_sel, ref_in, ref_comp, pll_clk} <= 4'(i);
				@(posedge clk);
				`CHK(sys_clk, b ? (ref_in & (~diff_sel | ~ref_comp)) : pll_clk)
			end
		end
		for (int i = 0; i < 8; i++) begin
			host.pw(dds_cfg_pkg::MODE_ADDR, {5'h00, mseq[i]});
			repeat (2) @(posedge clk);
			`CHK(mode, mex[mseq[i]])
			`CHK(caps, cex[mseq[i]])
		end
		fork
			host.pr(dds_cfg_pkg::MODE_ADDR, q);
			begin
				@(posedge clk);
				`CHK(pdata_oe, 1'b1)
			end
		join
		`CHK(q, 8'h07)
		host.pw(6'h15, 8'hA5);
		host.pr(6'h15, q);
		`CHK(q, 8'h00)
		// first word set to two to the 34th: one output phase step per cycle
		host.pw(dds_cfg_pkg::TUNE1_BASE + 6'h04, 8'h04);
		repeat (3) @(posedge clk);
		p0 = phase;
		@(posedge clk);
		p1 = phase;
		`CHK(14'(p1 - p0), 14'h0001)
		host.pw(dds_cfg_pkg::TUNE1_BASE + 6'h04, 8'h08);
		p0 = phase;
		`CHK((14'(p0 - p1) < 14'h0008), 1'b1)
		repeat (3) @(posedge clk);
		p0 = phase;
		@(posedge clk);
		`CHK(14'(phase - p0), 14'h0002)
		// the select pin is ignored in single-tone; in FSK it picks the empty second word
		pin_sel <= 1'b1;
		repeat (3) @(posedge clk);
		p0 = phase;
		@(posedge clk);
		`CHK(14'(phase - p0), 14'h0002)
		host.pw(dds_cfg_pkg::MODE_ADDR, 8'h01);
		repeat (3) @(posedge clk);
		p0 = phase;
		@(posedge clk);
		`CHK(14'(phase - p0), 14'h0000)
		host.pw(dds_cfg_pkg::MODE_ADDR, 8'h00);
		pin_sel <= 1'b0;
		host.pw(dds_cfg_pkg::AMP_LO, 8'hFF);
		host.pw(dds_cfg_pkg::AMP_HI, 8'h0F);
		repeat (2) @(posedge clk);
		`CHK(amp, 12'hFFF)
		host.sx(1'b0, dds_cfg_pkg::MODE_ADDR, 8'h03, q);
		`CHK(mode, dds_cfg_pkg::MODE_CHIRP)
		fork
			host.sx(1'b1, dds_cfg_pkg::MODE_ADDR, 8'h55, q);
			begin
				repeat (40) @(posedge clk);
				`CHK({sdio_oe, pdata_oe}, 2'b10)
			end
		join
		`CHK(q, 8'h03)
		host.sx(1'b0, dds_cfg_pkg::OUTSER_ADDR, 8'h01, q);
		host.sx(1'b0, dds_cfg_pkg::MODE_ADDR, 8'h04, q);
		`CHK(mode, dds_cfg_pkg::MODE_BPSK)
		host.sx(1'b0, dds_cfg_pkg::OUTSER_ADDR, 8'h03, q);
		fork
			host.sx(1'b1, dds_cfg_pkg::MODE_ADDR, 8'hAA, q);
			begin
				repeat (40) @(posedge clk);
				`CHK({sdio_oe, pdata_oe}, 2'b00)
			end
		join
		`CHK(q, 8'h04)
		// master reset in mid-run brings back the quiet single-tone state
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(mode, dds_cfg_pkg::MODE_SINGLE)
		`CHK({phase, amp}, 26'h0)
		`CHK(clk_cfg, 7'h04)
		end_sim();
	end
endmodule
